// File: design/tcp_params.svh
// constants for the timer compare, single-pulse and pwm block
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH
`define TCP_OFF_CTRL1 8'h00
`define TCP_OFF_CTRL2 8'h04
`define TCP_OFF_STAT 8'h08
`define TCP_OFF_CMP1_HI 8'h0C
`define TCP_OFF_CMP1_LO 8'h10
`define TCP_OFF_CMP2_HI 8'h14
`define TCP_OFF_CMP2_LO 8'h18
`define TCP_OFF_CNT 8'h1C
`define TCP_OFF_CAP1 8'h20
`define TCP_OFF_CAP2 8'h24
`define TCP_C1_CAPIE 7
`define TCP_C1_CMPIE 6
`define TCP_C1_FORCE2 4
`define TCP_C1_FORCE1 3
`define TCP_C1_LVL2 2
`define TCP_C1_EDGE1 1
`define TCP_C1_LVL1 0
`define TCP_C2_PEN1 7
`define TCP_C2_PEN2 6
`define TCP_C2_PULSE 5
`define TCP_C2_PWM 4
`define TCP_C2_TICK_HI 3
`define TCP_C2_TICK_LO 2
`define TCP_C2_EDGE2 1
`define TCP_C2_EXEDG 0
`define TCP_CMP_RST 16'h8000
`define TCP_CNT_RST 16'h0000
`define TCP_RELOAD 16'hFFFC
`define TCP_OPM_CAP 16'hFFFD
`define TCP_DIV2_MASK 3'h1
`define TCP_DIV4_MASK 3'h3
`define TCP_DIV8_MASK 3'h7
`define TCP_RESP_OK 2'h0
`define TCP_RESP_ERR 2'h2
`endif

// File: design/tcp_pkg.sv
// types shared by the timer compare block
package tcp_pkg;
  typedef enum logic [1:0] {
    TCP_DIV4 = 2'h0,
    TCP_DIV2 = 2'h1,
    TCP_DIV8 = 2'h2,
    TCP_EXT = 2'h3
  } tcp_tick_sel_t;

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic [2:0] div;
    logic tick;
  } tcp_tick_state_t;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [15:0] cnt;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic [1:0] cmp_ok;
    logic [1:0] ocf;
    logic [1:0] icf;
    logic [1:0] seen_oc;
    logic [1:0] seen_ic;
    logic [1:0] arm;
    logic [1:0] pin;
    logic [1:0] cap_s1;
    logic [1:0] cap_s2;
    logic [1:0] cap_prev;
    logic fresh;
    logic halt_prev;
    logic irq;
    logic awrdy;
    logic awfull;
    logic [7:0] awaddr;
    logic wrdy;
    logic wfull;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcp_state_t;
endpackage

// File: design/tcp_tick.sv
// timer tick divider with external clock edge detection
`timescale 1ns/10ps
`include "tcp_params.svh"
module tcp_tick (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] sel_i,
  input wire logic ext_pin_i,
  input wire logic ext_rise_i,
  input wire logic run_i,
  output logic tick_o
);
  tcp_pkg::tcp_tick_state_t st, nx;
  logic ext_edge;

  always_comb begin
    nx = st;
    nx.ext_s1 = ext_pin_i;
    nx.ext_s2 = st.ext_s1;
    nx.ext_prev = st.ext_s2;
    ext_edge = (st.ext_s2 != st.ext_prev) && (st.ext_s2 == ext_rise_i);
    nx.div = st.div + 3'h1;
    unique case (tcp_pkg::tcp_tick_sel_t'(sel_i))
      tcp_pkg::TCP_DIV2: nx.tick = (st.div & `TCP_DIV2_MASK) == `TCP_DIV2_MASK;
      tcp_pkg::TCP_DIV4: nx.tick = (st.div & `TCP_DIV4_MASK) == `TCP_DIV4_MASK;
      tcp_pkg::TCP_DIV8: nx.tick = st.div == `TCP_DIV8_MASK;
      tcp_pkg::TCP_EXT: nx.tick = ext_edge;
    endcase
    // halt stops ticks but not the divider, so resume has no glitch
    nx.tick = nx.tick & run_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign tick_o = st.tick;
endmodule

// File: design/tcp_top.sv
// timer compare, single-pulse and pwm block with axi4-lite registers
`timescale 1ns/10ps
`include "tcp_params.svh"
module tcp_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [1:0] capture_pin_i,
  input wire logic ext_clk_pin_i,
  input wire logic halt_i,
  output logic [1:0] compare_output_pin_o,
  output logic [1:0] compare_pin_enable_o,
  output logic timer_irq_o
);
  tcp_pkg::tcp_state_t st, nx;
  tcp_pkg::tcp_tick_sel_t tick_sel;
  logic tick;
  logic mode_pwm;
  logic mode_opm;
  logic [1:0] cap_edge;
  logic [1:0] hit;
  logic load;
  logic wrap2;
  logic [7:0] waddr;
  logic [7:0] raddr;
  logic do_wr;
  logic do_rd;

  function automatic logic [7:0] word_of(input logic [7:0] a);
    word_of = {a[7:2], 2'h0};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    unique case (word_of(a))
      `TCP_OFF_CTRL1, `TCP_OFF_CTRL2, `TCP_OFF_STAT,
      `TCP_OFF_CMP1_HI, `TCP_OFF_CMP1_LO, `TCP_OFF_CMP2_HI,
      `TCP_OFF_CMP2_LO, `TCP_OFF_CNT, `TCP_OFF_CAP1,
      `TCP_OFF_CAP2: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // the match point moves by one count on the slower ticks
  function automatic logic [15:0] cmp_target(input logic [15:0] v,
      input tcp_pkg::tcp_tick_sel_t s);
    cmp_target = (s == tcp_pkg::TCP_DIV2) ? v : v + 16'h0001;
  endfunction

  function automatic logic [31:0] rd_mux(input tcp_pkg::tcp_state_t s,
      input logic [7:0] a);
    unique case (word_of(a))
      `TCP_OFF_CTRL1: rd_mux = {24'h00_0000, s.ctrl1};
      `TCP_OFF_CTRL2: rd_mux = {24'h00_0000, s.ctrl2};
      `TCP_OFF_STAT: rd_mux = {24'h00_0000, s.icf[0], s.ocf[0], 1'b0,
                               s.icf[1], s.ocf[1], 3'h0};
      `TCP_OFF_CMP1_HI: rd_mux = {24'h00_0000, s.cmp1[15:8]};
      `TCP_OFF_CMP1_LO: rd_mux = {24'h00_0000, s.cmp1[7:0]};
      `TCP_OFF_CMP2_HI: rd_mux = {24'h00_0000, s.cmp2[15:8]};
      `TCP_OFF_CMP2_LO: rd_mux = {24'h00_0000, s.cmp2[7:0]};
      `TCP_OFF_CNT: rd_mux = {16'h0000, s.cnt};
      `TCP_OFF_CAP1: rd_mux = {16'h0000, s.cap1};
      `TCP_OFF_CAP2: rd_mux = {16'h0000, s.cap2};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  assign tick_sel = tcp_pkg::tcp_tick_sel_t'(
      st.ctrl2[`TCP_C2_TICK_HI:`TCP_C2_TICK_LO]);

  tcp_tick u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(st.ctrl2[`TCP_C2_TICK_HI:`TCP_C2_TICK_LO]),
    .ext_pin_i(ext_clk_pin_i),
    .ext_rise_i(st.ctrl2[`TCP_C2_EXEDG]),
    .run_i(!halt_i),
    .tick_o(tick)
  );

  always_comb begin
    nx = st;
    mode_pwm = st.ctrl2[`TCP_C2_PWM];
    mode_opm = st.ctrl2[`TCP_C2_PULSE] & ~mode_pwm;
    load = 1'b0;
    waddr = word_of(st.awaddr);
    raddr = word_of(s_axi_araddr_i);
    do_wr = st.awfull & st.wfull & ~st.bvalid;
    do_rd = s_axi_arvalid_i & st.arrdy;

    // capture pin synchronisers and edge detection
    nx.cap_s1 = capture_pin_i;
    nx.cap_s2 = st.cap_s1;
    nx.cap_prev = st.cap_s2;
    cap_edge[0] = (st.cap_s2[0] != st.cap_prev[0]) &&
                  (st.cap_s2[0] == st.ctrl1[`TCP_C1_EDGE1]);
    cap_edge[1] = (st.cap_s2[1] != st.cap_prev[1]) &&
                  (st.cap_s2[1] == st.ctrl2[`TCP_C2_EDGE2]);

    // compare keeps working whatever the pin enables say
    hit[0] = st.fresh & st.cmp_ok[0] & ~halt_i &
             (st.cnt == cmp_target(st.cmp1, tick_sel));
    hit[1] = st.fresh & st.cmp_ok[1] & ~halt_i &
             (st.cnt == cmp_target(st.cmp2, tick_sel));
    // at div2 the reload waits for the tick ending the matched count
    wrap2 = (tick_sel == tcp_pkg::TCP_DIV2) ? tick & st.cmp_ok[1] & ~halt_i &
            (st.cnt == st.cmp2) : hit[1];

    // write address and data channels, taken in either order
    if (s_axi_awvalid_i && st.awrdy) begin
      nx.awfull = 1'b1;
      nx.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st.wrdy) begin
      nx.wfull = 1'b1;
      nx.wdata = s_axi_wdata_i[7:0];
      nx.wstrb0 = s_axi_wstrb_i[0];
    end
    if (st.bvalid && s_axi_bready_i) begin
      nx.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready_i) begin
      nx.rvalid = 1'b0;
    end

    // software side effects first, so hardware sets below win
    if (do_wr) begin
      nx.awfull = 1'b0;
      nx.wfull = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = is_mapped(st.awaddr) ? `TCP_RESP_OK : `TCP_RESP_ERR;
      if (st.wstrb0) begin
        unique case (waddr)
          `TCP_OFF_CTRL1: nx.ctrl1 = st.wdata;
          `TCP_OFF_CTRL2: nx.ctrl2 = st.wdata;
          `TCP_OFF_CMP1_HI: begin
            nx.cmp1[15:8] = st.wdata;
            nx.cmp_ok[0] = 1'b0;
          end
          `TCP_OFF_CMP1_LO: nx.cmp1[7:0] = st.wdata;
          `TCP_OFF_CMP2_HI: begin
            nx.cmp2[15:8] = st.wdata;
            nx.cmp_ok[1] = 1'b0;
          end
          `TCP_OFF_CMP2_LO: nx.cmp2[7:0] = st.wdata;
          default: ;
        endcase
      end
      // a low byte write, strobed or not, re-enables compare and ends flag clearing
      if (waddr == `TCP_OFF_CMP1_LO) begin
        nx.cmp_ok[0] = 1'b1;
        nx.ocf[0] = st.ocf[0] & ~st.seen_oc[0];
        nx.seen_oc[0] = 1'b0;
      end
      if (waddr == `TCP_OFF_CMP2_LO) begin
        nx.cmp_ok[1] = 1'b1;
        nx.ocf[1] = st.ocf[1] & ~st.seen_oc[1];
        nx.seen_oc[1] = 1'b0;
      end
    end
    if (do_rd) begin
      nx.rvalid = 1'b1;
      nx.rdata = rd_mux(st, s_axi_araddr_i);
      nx.rresp = is_mapped(s_axi_araddr_i) ? `TCP_RESP_OK : `TCP_RESP_ERR;
      unique case (raddr)
        `TCP_OFF_STAT: begin
          nx.seen_oc = st.ocf;
          nx.seen_ic = st.icf;
        end
        `TCP_OFF_CMP1_LO: begin
          nx.ocf[0] = st.ocf[0] & ~st.seen_oc[0];
          nx.seen_oc[0] = 1'b0;
        end
        `TCP_OFF_CMP2_LO: begin
          nx.ocf[1] = st.ocf[1] & ~st.seen_oc[1];
          nx.seen_oc[1] = 1'b0;
        end
        `TCP_OFF_CAP1: begin
          nx.icf[0] = st.icf[0] & ~st.seen_ic[0];
          nx.seen_ic[0] = 1'b0;
        end
        `TCP_OFF_CAP2: begin
          nx.icf[1] = st.icf[1] & ~st.seen_ic[1];
          nx.seen_ic[1] = 1'b0;
        end
        default: ;
      endcase
    end

    // free-running counter, frozen while halted
    if (tick && !halt_i) begin
      nx.cnt = st.cnt + 16'h0001;
    end

    if (!halt_i) begin
      // capture two works in every mode
      if (cap_edge[1]) begin
        nx.icf[1] = 1'b1;
        nx.cap2 = st.cnt;
      end
      if (mode_pwm) begin
        // capture pin one is disconnected here
        if (hit[0] && st.ctrl2[`TCP_C2_PEN1]) begin
          nx.pin[0] = st.ctrl1[`TCP_C1_LVL1];
        end
        if (hit[1]) begin
          nx.icf[0] = 1'b1;
          if (st.ctrl2[`TCP_C2_PEN1]) begin
            nx.pin[0] = st.ctrl1[`TCP_C1_LVL2];
          end
        end
        if (wrap2) begin
          nx.cnt = `TCP_RELOAD;
          load = 1'b1;
        end
      end else if (mode_opm) begin
        if (hit[0] && st.ctrl2[`TCP_C2_PEN1]) begin
          nx.pin[0] = st.ctrl1[`TCP_C1_LVL1];
        end
        if (hit[1]) begin
          nx.ocf[1] = 1'b1;
        end
        // a trigger edge restarts the pulse even while one runs
        if (cap_edge[0]) begin
          nx.cnt = `TCP_RELOAD;
          load = 1'b1;
          nx.icf[0] = 1'b1;
          nx.cap1 = `TCP_OPM_CAP;
          if (st.ctrl2[`TCP_C2_PEN1]) begin
            nx.pin[0] = st.ctrl1[`TCP_C1_LVL2];
          end
        end
      end else begin
        if (cap_edge[0]) begin
          nx.icf[0] = 1'b1;
          nx.cap1 = st.cnt;
        end
        for (int i = 0; i < 2; i++) begin
          if (hit[i]) begin
            nx.ocf[i] = 1'b1;
            if (st.ctrl2[`TCP_C2_PEN1 - i]) begin
              nx.pin[i] = st.ctrl1[(i == 0) ? `TCP_C1_LVL1 : `TCP_C1_LVL2];
            end
          end
          // force drives the level but never raises a flag
          if (st.ctrl1[`TCP_C1_FORCE1 + i] && st.ctrl2[`TCP_C2_PEN1 - i])
          begin
            nx.pin[i] = st.ctrl1[(i == 0) ? `TCP_C1_LVL1 : `TCP_C1_LVL2];
          end
        end
      end
    end else begin
      // edges during halt are remembered, not captured yet; pin one's only in normal mode
      if (cap_edge[1]) begin
        nx.arm[1] = 1'b1;
      end
      if (cap_edge[0] && !mode_pwm && !mode_opm) begin
        nx.arm[0] = 1'b1;
      end
    end

    // leaving halt completes armed captures with the held count
    nx.halt_prev = halt_i;
    if (st.halt_prev && !halt_i) begin
      if (st.arm[0]) begin
        nx.icf[0] = 1'b1;
        nx.cap1 = st.cnt;
      end
      if (st.arm[1]) begin
        nx.icf[1] = 1'b1;
        nx.cap2 = st.cnt;
      end
      nx.arm = 2'h0;
    end

    nx.fresh = tick | load;
    // the cpu applies its own global mask; this line also wakes it
    nx.irq = (nx.ctrl1[`TCP_C1_CAPIE] & (|nx.icf)) |
             (nx.ctrl1[`TCP_C1_CMPIE] & (|nx.ocf));
    nx.awrdy = ~nx.awfull & ~nx.bvalid;
    nx.wrdy = ~nx.wfull & ~nx.bvalid;
    nx.arrdy = ~nx.rvalid;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.cmp1 <= `TCP_CMP_RST;
      st.cmp2 <= `TCP_CMP_RST;
      st.cnt <= `TCP_CNT_RST;
      st.cmp_ok <= 2'h3;
      st.awrdy <= 1'b1;
      st.wrdy <= 1'b1;
      st.arrdy <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign s_axi_awready_o = st.awrdy;
  assign s_axi_wready_o = st.wrdy;
  assign s_axi_bvalid_o = st.bvalid;
  assign s_axi_bresp_o = st.bresp;
  assign s_axi_arready_o = st.arrdy;
  assign s_axi_rvalid_o = st.rvalid;
  assign s_axi_rdata_o = st.rdata;
  assign s_axi_rresp_o = st.rresp;
  assign compare_output_pin_o = st.pin;
  assign compare_pin_enable_o = {st.ctrl2[`TCP_C2_PEN2],
                                 st.ctrl2[`TCP_C2_PEN1]};
  assign timer_irq_o = st.irq;

  AST_PWM_NO_OCF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(st.ocf[1]) |-> !$past(mode_pwm))
    else $error("compare flag two set in pwm mode");

  AST_OPM_NO_COMPARE_FLAG_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(st.ocf[0]) |-> !$past(mode_opm) && !$past(mode_pwm))
    else $error("compare flag one set in pulse or pwm mode");

  AST_CMP_INHIBIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(st.ocf[0]) |-> $past(st.cmp_ok[0]))
    else $error("compare fired while high byte pending");

  AST_PWM_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_pwm && wrap2 |=> st.cnt == `TCP_RELOAD)
    else $error("pwm period match did not reload counter");

  AST_PWM_ICF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_pwm && hit[1] |=> st.icf[0])
    else $error("pwm period match did not set capture flag one");

  AST_OPM_TRIG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_opm && cap_edge[0] && !halt_i
    |=> st.cap1 == `TCP_OPM_CAP && st.cnt == `TCP_RELOAD && st.icf[0])
    else $error("pulse trigger did not load counter and capture");

  AST_PIN_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !st.ctrl2[`TCP_C2_PEN2] |=> st.pin[1] == $past(st.pin[1]))
    else $error("disabled compare pin changed level");

  AST_FORCE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !mode_pwm && !mode_opm && !halt_i && st.ctrl1[`TCP_C1_FORCE1] &&
    st.ctrl2[`TCP_C2_PEN1] |=> st.pin[0] == $past(st.ctrl1[`TCP_C1_LVL1]))
    else $error("forced level not copied to pin one");

  AST_HALT_FREEZE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    halt_i |=> $stable(st.cnt) && $stable(st.pin))
    else $error("counter moved during halt");
endmodule

// File: tb/tcp_pin_model.sv
// external circuitry on the capture pins and the external tick pin
`timescale 1ns/10ps
module tcp_pin_model (
  input wire logic clk_i,
  output logic [1:0] capture_pin_o,
  output logic ext_clk_o
);
  initial begin
    capture_pin_o = 2'h0;
    ext_clk_o = 1'b0;
  end
  // one high pulse: both edges appear, the edge select picks one
  task pulse(input int idx);
    @(posedge clk_i);
    capture_pin_o[idx] <= 1'b1;
    repeat (6) @(posedge clk_i);
    capture_pin_o[idx] <= 1'b0;
  endtask
  // tick pin toggles only inside a burst, eight clocks a period
  task ext_burst(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
endmodule

// File: tb/timer_compare_pulse_pwm_tb_top.sv
// self-checking bench for the timer compare, single-pulse and pwm block
`timescale 1ns/10ps
`include "tcp_params.svh"
module timer_compare_pulse_pwm_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, halt = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, ext;
  logic [1:0] bresp, rresp, pin, pen, cap;
  logic [31:0] rdata, d, a;
  int fails = 0, cmp_count = 0, cycles = 0, seed = 20774;
  int last_rise = 0, period = 0, high = 0, rises = 0, v;
  logic prev = 1'b0;
  int divs[4] = '{4, 2, 8, 0};

  always #20 clk_i = ~clk_i;

  tcp_pin_model partner (.clk_i(clk_i), .capture_pin_o(cap),
    .ext_clk_o(ext));
  tcp_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .capture_pin_i(cap), .ext_clk_pin_i(ext),
    .halt_i(halt), .compare_output_pin_o(pin),
    .compare_pin_enable_o(pen), .timer_irq_o(irq));

  // pwm waveform monitor: rise-to-rise period and high time in clocks
  always @(posedge clk_i) begin
    cycles++;
    prev <= pin[0];
    if (pin[0] === 1'b1 && prev === 1'b0) begin
      period = cycles - last_rise;
      last_rise = cycles;
      rises++;
    end
    if (pin[0] === 1'b0 && prev === 1'b1)
      high = cycles - last_rise;
    if (cycles > 20000) begin
      fails++;
      finish_test();
    end
  end

  task finish_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task chkr(input string n, input int lo, input int hi,
    input logic [31:0] g);
    cmp_count++;
    if (!(g >= lo && g <= hi) || $isunknown(g)) begin
      fails++;
      $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask

  task wr(input logic [7:0] ad, input logic [7:0] dt);
    logic aw, w;
    logic [31:0] rn;
    aw = 1'b1;
    w = 1'b1;
    // ignored address, data and strobe bits are random
    rn = $random(seed);
    @(posedge clk_i);
    awaddr <= {ad[7:2], rn[1:0]};
    wdata <= {rn[31:8], dt};
    wstrb <= {rn[3:1], 1'b1};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task rd(input logic [7:0] ad, output logic [31:0] dt,
    output logic [1:0] r);
    @(posedge clk_i);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dt = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task rc(input string n, input logic [7:0] ad, input logic [31:0] e);
    logic [1:0] r;
    rd(ad, d, r);
    chk(n, e, d);
  endtask

  task do_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask

  initial begin
    logic [1:0] r;
    do_reset();
    rc("ctrl1", `TCP_OFF_CTRL1, 32'h0000_0000);
    rc("ctrl2", `TCP_OFF_CTRL2, 32'h0000_0000);
    rc("status", `TCP_OFF_STAT, 32'h0000_0000);
    rc("cmp1 hi", `TCP_OFF_CMP1_HI, 32'h0000_0080);
    rd(8'h28, d, r);
    chk("unmapped resp", `TCP_RESP_ERR, r);
    // normal compare, div2, pin two disabled, cmp1 left half written
    wr(`TCP_OFF_CTRL2, 8'h84);
    wr(`TCP_OFF_CTRL1, 8'h45);
    wr(`TCP_OFF_CMP1_HI, 8'h00);
    wr(`TCP_OFF_CMP2_HI, 8'h00);
    wr(`TCP_OFF_CMP2_LO, 8'h30);
    repeat (120) @(posedge clk_i);
    rc("status half", `TCP_OFF_STAT, 32'h0000_0008);
    chk("pin enables", 2'b01, pen);
    chk("irq cmp2", 1'b1, irq);
    rc("cmp2 lo", `TCP_OFF_CMP2_LO, 32'h0000_0030);
    rc("compare_flag_two clear", `TCP_OFF_STAT, 32'h0000_0000);
    rd(`TCP_OFF_CNT, a, r);
    // new timeout from the current count
    v = a + 8'h20 + ($random(seed) & 15);
    wr(`TCP_OFF_CMP1_LO, v[7:0]);
    chk("pin before", 1'b0, pin[0]);
    repeat (120) @(posedge clk_i);
    rc("status match", `TCP_OFF_STAT, 32'h0000_0040);
    chk("pin match", 1'b1, pin[0]);
    // forced levels in normal mode never set a flag
    do_reset();
    wr(`TCP_OFF_CTRL2, 8'h80);
    wr(`TCP_OFF_CTRL1, 8'h08);
    repeat (4) @(posedge clk_i);
    chk("force low", 1'b0, pin[0]);
    wr(`TCP_OFF_CTRL1, 8'h09);
    repeat (4) @(posedge clk_i);
    chk("force high", 1'b1, pin[0]);
    rc("force flags", `TCP_OFF_STAT, 32'h0000_0000);
    // single pulse of 63 ticks, compare two still times out
    do_reset();
    wr(`TCP_OFF_CMP1_HI, 8'h00);
    wr(`TCP_OFF_CMP1_LO, 8'h3B);
    wr(`TCP_OFF_CMP2_HI, 8'h00);
    wr(`TCP_OFF_CMP2_LO, 8'h20);
    wr(`TCP_OFF_CTRL1, 8'h86);
    wr(`TCP_OFF_CTRL2, 8'hE4);
    partner.pulse(0);
    rc("trigger flag", `TCP_OFF_STAT, 32'h0000_0080);
    chk("pulse on", 1'b1, pin[0]);
    chk("irq capture", 1'b1, irq);
    rc("cap1 load", `TCP_OFF_CAP1, 32'h0000_FFFD);
    repeat (70) @(posedge clk_i);
    chk("pulse held", 1'b1, pin[0]);
    repeat (60) @(posedge clk_i);
    chk("pulse end", 1'b0, pin[0]);
    chk("pin two idle", 1'b0, pin[1]);
    rc("pulse flags", `TCP_OFF_STAT, 32'h0000_0008);
    chk("irq off", 1'b0, irq);
    partner.pulse(1);
    repeat (8) @(posedge clk_i);
    rc("cap2 flag", `TCP_OFF_STAT, 32'h0000_0018);
    partner.pulse(0);
    repeat (4) @(posedge clk_i);
    rd(`TCP_OFF_CNT, a, r);
    chk("counter reset", 1'b1, a[15:0] >= 16'hFFFC || a < 16);
    // pwm wins over single pulse; compare two sets the period
    do_reset();
    v = 8 + ($random(seed) & 7);
    wr(`TCP_OFF_CMP1_HI, 8'h00);
    wr(`TCP_OFF_CMP1_LO, v[7:0]);
    wr(`TCP_OFF_CMP2_HI, 8'h00);
    wr(`TCP_OFF_CMP2_LO, 8'h30);
    wr(`TCP_OFF_CTRL1, 8'h84);
    wr(`TCP_OFF_CTRL2, 8'hB4);
    partner.pulse(0);
    repeat (500) @(posedge clk_i);
    chk("pwm period", (8'h30 + 5) * 2, period);
    chk("pwm high", (v + 5) * 2, high);
    rc("pwm flags", `TCP_OFF_STAT, 32'h0000_0080);
    rc("cap1 unused", `TCP_OFF_CAP1, 32'h0000_0000);
    rd(`TCP_OFF_CNT, a, r);
    chk("pwm range", 1'b1, a[15:0] >= 16'hFFFC || a <= 8'h31);
    partner.pulse(1);
    // wait a whole period so the period match sets capture flag one again
    repeat (110) @(posedge clk_i);
    rc("pwm cap2", `TCP_OFF_STAT, 32'h0000_0090);
    wr(`TCP_OFF_CTRL1, 8'h85);
    v = rises;
    repeat (250) @(posedge clk_i);
    chk("steady level", 1'b1, pin[0]);
    chk("no edges", v + 1 >= rises, 1'b1);
    // every tick source, external pin only inside a burst
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr(`TCP_OFF_CTRL2, (c << 2) | (c == 3));
      rd(`TCP_OFF_CNT, a, r);
      if (c == 3)
        partner.ext_burst(16);
      else
        repeat (128) @(posedge clk_i);
      rd(`TCP_OFF_CNT, d, r);
      v = (c == 3) ? 16 : 128 / divs[c];
      chkr("tick rate", v - 1, v + 1, d - a);
    end
    // halt freezes the count; a capture seen meanwhile completes on exit
    do_reset();
    wr(`TCP_OFF_CTRL2, 8'h04);
    @(posedge clk_i);
    halt <= ~halt;
    repeat (4) @(posedge clk_i);
    rd(`TCP_OFF_CNT, a, r);
    partner.pulse(1);
    repeat (40) @(posedge clk_i);
    rc("halt count", `TCP_OFF_CNT, a);
    halt <= ~halt;
    repeat (6) @(posedge clk_i);
    rc("halt capture", `TCP_OFF_STAT, 32'h0000_0010);
    rd(`TCP_OFF_CAP2, d, r);
    chkr("capture at exit", a, a + 1, d);
    finish_test();
  end
endmodule
